// ### design/rcd_decode.sv
// Combinational decode of a render command word into per-primitive controls.
// Assumes the caller registers the result; unit enables come from stipple/span state.
`timescale 1ns/1ps
module rcd_decode (
  // Command and qualifiers
  input wire logic [31:0] command_in,
  input wire logic [15:0] count_in,
  input wire logic unit_area_en_in,
  input wire logic unit_line_en_in,
  input wire logic [1:0] span_op_in,
  // Decoded controls
  output rcd_pkg::rcd_ctrl_s ctrl_out
);

  rcd_pkg::rcd_prim_e prim;
  logic is_trap;

  always_comb begin
    prim = rcd_pkg::rcd_prim_e'(command_in[rcd_pkg::RCD_BIT_PRIM_LO +: 2]);
    is_trap = (prim == rcd_pkg::RCD_PRIM_TRAP);
    ctrl_out = '0;
    ctrl_out.prim = prim;
    ctrl_out.start = (prim != rcd_pkg::RCD_PRIM_RSVD);
    ctrl_out.area_pattern_gate = command_in[rcd_pkg::RCD_BIT_AREA] & unit_area_en_in;
    ctrl_out.line_pattern_gate = command_in[rcd_pkg::RCD_BIT_LINE] & unit_line_en_in;
    ctrl_out.line_pattern_restart = command_in[rcd_pkg::RCD_BIT_RESTART] & ctrl_out.line_pattern_gate;
    ctrl_out.span_fill_select = command_in[rcd_pkg::RCD_BIT_FILL] & is_trap;
    ctrl_out.span_op_field = ctrl_out.span_fill_select ? span_op_in : 2'h0;
    ctrl_out.block_fill_size = rcd_pkg::RCD_BLOCK_FILL;
    ctrl_out.edge_smoothing_on = command_in[rcd_pkg::RCD_BIT_SMOOTH] & is_trap;
    ctrl_out.subsample_grid_select = command_in[rcd_pkg::RCD_BIT_GRID];
    ctrl_out.dot_table_step_select = command_in[rcd_pkg::RCD_BIT_TABLE] & ctrl_out.edge_smoothing_on;
    ctrl_out.count = count_in;
    case (prim)
      rcd_pkg::RCD_PRIM_LINE: ctrl_out.count_unit = rcd_pkg::RCD_UNIT_PIXELS;
      rcd_pkg::RCD_PRIM_TRAP: ctrl_out.count_unit = ctrl_out.edge_smoothing_on ?
          rcd_pkg::RCD_UNIT_SUBLINES : rcd_pkg::RCD_UNIT_SCANLINES;
      default: ctrl_out.count_unit = rcd_pkg::RCD_UNIT_DIAMETER;
    endcase
  end

endmodule : rcd_decode

// ### design/rcd_pkg.sv
// Constants, register map and carrier types for the render command decoder.
// Assumes a 32-bit AXI4-Lite register port and a single 50 MHz core clock.
// Function
// - Area stippling only when command bit 0 and the unit's area enable are set.
// - Line stippling only when command bit 1 and the unit's line enable are set.
// - Bit 2 clears line pattern counters at primitive start, if line stippling enabled.
// - With bit 2 clear, line pattern counters continue across primitives.
// - Bit 3 with trapezoid selects span fill of the span op kind.
// - Bits 4 and 5 are ignored; block fill size is always 32 pixels.
// - Bits 7:6 select primitive: 0 line, 1 trapezoid, 2 point.
// - Bit 8 with trapezoid enables sub-scanline generation and per-fragment coverage.
// - Bit 9 selects an 8x8 subsample grid, else 4x4.
// - Bits 10 and 8 with trapezoid take x steps from the point table.
// - Point table has four words; the register address selects the word written.
// - The 16-bit count means pixels, scanlines, sub-scanlines or point diameter.
package rcd_pkg;

  // Register byte offsets
  localparam logic [7:0] RCD_OFF_COMMAND = 8'h00;
  localparam logic [7:0] RCD_OFF_COUNT = 8'h04;
  localparam logic [7:0] RCD_OFF_UNIT_CTRL = 8'h08;
  localparam logic [7:0] RCD_OFF_STATUS = 8'h0C;
  localparam logic [7:0] RCD_OFF_LINE_CNT = 8'h10;
  localparam logic [7:0] RCD_OFF_TABLE0 = 8'h20;
  localparam logic [7:0] RCD_OFF_TABLE3 = 8'h2C;

  // Command field positions
  localparam int RCD_BIT_AREA = 0;
  localparam int RCD_BIT_LINE = 1;
  localparam int RCD_BIT_RESTART = 2;
  localparam int RCD_BIT_FILL = 3;
  localparam int RCD_BIT_PRIM_LO = 6;
  localparam int RCD_BIT_SMOOTH = 8;
  localparam int RCD_BIT_GRID = 9;
  localparam int RCD_BIT_TABLE = 10;

  // Unit control field positions
  localparam int RCD_UBIT_AREA = 0;
  localparam int RCD_UBIT_LINE = 1;
  localparam int RCD_UBIT_SPAN_LO = 4;

  // Reset values and sizes
  localparam logic [31:0] RCD_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RCD_RST_COUNT = 16'h0000;
  localparam logic [5:0] RCD_BLOCK_FILL = 6'h20;
  localparam int RCD_TABLE_WORDS = 4;

  localparam logic [1:0] RCD_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCD_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RCD_PRIM_LINE = 2'h0,
    RCD_PRIM_TRAP = 2'h1,
    RCD_PRIM_POINT = 2'h2,
    RCD_PRIM_RSVD = 2'h3
  } rcd_prim_e;

  typedef enum logic [1:0] {
    RCD_UNIT_PIXELS,
    RCD_UNIT_SCANLINES,
    RCD_UNIT_SUBLINES,
    RCD_UNIT_DIAMETER
  } rcd_count_unit_e;

  // Decoded per-primitive controls
  typedef struct packed {
    logic start;
    rcd_prim_e prim;
    logic area_pattern_gate;
    logic line_pattern_gate;
    logic line_pattern_restart;
    logic span_fill_select;
    logic [1:0] span_op_field;
    logic edge_smoothing_on;
    logic subsample_grid_select;
    logic dot_table_step_select;
    logic [5:0] block_fill_size;
    rcd_count_unit_e count_unit;
    logic [15:0] count;
  } rcd_ctrl_s;

endpackage : rcd_pkg

// ### design/rcd_top.sv
// Render command decoder top: AXI4-Lite slave, command decode, line pattern counter, step table.
// Assumes one clock, synchronous inputs, and downstream units consuming the one-cycle start pulse.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rcd_top (
  // Clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Rasterizer side
  input wire logic fragment_step_in,
  input wire logic raster_busy_in,
  output rcd_pkg::rcd_ctrl_s ctrl_out,
  output logic [15:0] line_pattern_count_out,
  output logic [31:0] dot_step_word_out,
  input wire logic [1:0] dot_step_index_in
);

  // Reset synchroniser
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_n = rst_sync_r;

  // Write channel state
  logic aw_held_r, aw_held_nxt;
  logic w_held_r, w_held_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  // Read channel state
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  // Register state
  logic [31:0] command_r, command_nxt;
  logic [15:0] count_r, count_nxt;
  logic [31:0] unit_ctrl_r, unit_ctrl_nxt;
  logic [31:0] table_r [rcd_pkg::RCD_TABLE_WORDS];
  logic [31:0] table_nxt [rcd_pkg::RCD_TABLE_WORDS];
  rcd_pkg::rcd_ctrl_s ctrl_r, ctrl_nxt;
  logic [15:0] line_cnt_r, line_cnt_nxt;
  logic [31:0] dot_word_r, dot_word_nxt;

  logic do_write;
  logic cmd_write;
  logic [31:0] wmask;
  logic [31:0] cmd_merged;
  rcd_pkg::rcd_ctrl_s decoded;

  // Byte lane mask, one lane per strobe bit
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{w_strb_r[gi]}};
    end
  endgenerate

  // Write commits only when both halves are in and no response is pending
  assign do_write = aw_held_r & w_held_r & ~bvalid_r;
  assign cmd_write = do_write & (aw_addr_r[7:2] == rcd_pkg::RCD_OFF_COMMAND[7:2]);
  assign cmd_merged = (command_r & ~wmask) | (w_data_r & wmask);

  rcd_decode u_decode (
    .command_in(cmd_merged),
    .count_in(count_r),
    .unit_area_en_in(unit_ctrl_r[rcd_pkg::RCD_UBIT_AREA]),
    .unit_line_en_in(unit_ctrl_r[rcd_pkg::RCD_UBIT_LINE]),
    .span_op_in(unit_ctrl_r[rcd_pkg::RCD_UBIT_SPAN_LO +: 2]),
    .ctrl_out(decoded)
  );

  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    command_nxt = command_r;
    count_nxt = count_r;
    unit_ctrl_nxt = unit_ctrl_r;
    for (int i = 0; i < rcd_pkg::RCD_TABLE_WORDS; i++) begin
      table_nxt[i] = table_r[i];
    end
    if (s_axi_awvalid_in && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !w_held_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata_in;
      w_strb_nxt = s_axi_wstrb_in;
    end
    if (bvalid_r && s_axi_bready_in) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = rcd_pkg::RCD_RESP_OKAY;
      if (aw_addr_r[7:2] == rcd_pkg::RCD_OFF_COMMAND[7:2]) begin
        command_nxt = cmd_merged;
      end else if (aw_addr_r[7:2] == rcd_pkg::RCD_OFF_COUNT[7:2]) begin
        count_nxt = (count_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
      end else if (aw_addr_r[7:2] == rcd_pkg::RCD_OFF_UNIT_CTRL[7:2]) begin
        unit_ctrl_nxt = (unit_ctrl_r & ~wmask) | (w_data_r & wmask);
      end else if (aw_addr_r >= rcd_pkg::RCD_OFF_TABLE0 && aw_addr_r <= rcd_pkg::RCD_OFF_TABLE3) begin
        // Word chosen by the address of the write
        table_nxt[aw_addr_r[3:2]] = (table_r[aw_addr_r[3:2]] & ~wmask) | (w_data_r & wmask);
      end else begin
        bresp_nxt = rcd_pkg::RCD_RESP_SLVERR;
      end
    end
  end

  // Read path
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready_in) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid_in && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = rcd_pkg::RCD_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (s_axi_araddr_in[7:2] == rcd_pkg::RCD_OFF_COMMAND[7:2]) begin
        // Command is write-only; reads give zero
        rdata_nxt = 32'h0000_0000;
      end else if (s_axi_araddr_in[7:2] == rcd_pkg::RCD_OFF_COUNT[7:2]) begin
        rdata_nxt = {16'h0000, count_r};
      end else if (s_axi_araddr_in[7:2] == rcd_pkg::RCD_OFF_UNIT_CTRL[7:2]) begin
        rdata_nxt = unit_ctrl_r;
      end else if (s_axi_araddr_in[7:2] == rcd_pkg::RCD_OFF_STATUS[7:2]) begin
        rdata_nxt = {7'h00, ctrl_r.block_fill_size, ctrl_r.count_unit, 5'h00, ctrl_r.dot_table_step_select,
                     ctrl_r.subsample_grid_select, ctrl_r.edge_smoothing_on, ctrl_r.span_op_field,
                     ctrl_r.span_fill_select, ctrl_r.line_pattern_restart, ctrl_r.line_pattern_gate,
                     ctrl_r.area_pattern_gate, ctrl_r.prim, raster_busy_in};
      end else if (s_axi_araddr_in[7:2] == rcd_pkg::RCD_OFF_LINE_CNT[7:2]) begin
        rdata_nxt = {16'h0000, line_cnt_r};
      end else if (s_axi_araddr_in >= rcd_pkg::RCD_OFF_TABLE0 && s_axi_araddr_in <= rcd_pkg::RCD_OFF_TABLE3) begin
        rdata_nxt = table_r[s_axi_araddr_in[3:2]];
      end else begin
        rresp_nxt = rcd_pkg::RCD_RESP_SLVERR;
      end
    end
  end

  // Decode registered per command; start pulses one cycle
  always_comb begin
    ctrl_nxt = ctrl_r;
    ctrl_nxt.start = 1'b0;
    line_cnt_nxt = line_cnt_r;
    if (cmd_write) begin
      ctrl_nxt = decoded;
      if (decoded.start && decoded.line_pattern_restart) begin
        line_cnt_nxt = 16'h0000;
      end
    end else if (fragment_step_in && ctrl_r.line_pattern_gate) begin
      // Counter carries over between primitives unless restarted
      line_cnt_nxt = line_cnt_r + 16'h0001;
    end
    dot_word_nxt = ctrl_r.dot_table_step_select ? table_r[dot_step_index_in] : 32'h0000_0000;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= rcd_pkg::RCD_RST_WORD;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= rcd_pkg::RCD_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= rcd_pkg::RCD_RST_WORD;
      rresp_r <= rcd_pkg::RCD_RESP_OKAY;
      command_r <= rcd_pkg::RCD_RST_WORD;
      count_r <= rcd_pkg::RCD_RST_COUNT;
      unit_ctrl_r <= rcd_pkg::RCD_RST_WORD;
      for (int i = 0; i < rcd_pkg::RCD_TABLE_WORDS; i++) begin
        table_r[i] <= rcd_pkg::RCD_RST_WORD;
      end
      ctrl_r <= '0;
      line_cnt_r <= rcd_pkg::RCD_RST_COUNT;
      dot_word_r <= rcd_pkg::RCD_RST_WORD;
    end else if (clk_en_in) begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      command_r <= command_nxt;
      count_r <= count_nxt;
      unit_ctrl_r <= unit_ctrl_nxt;
      for (int i = 0; i < rcd_pkg::RCD_TABLE_WORDS; i++) begin
        table_r[i] <= table_nxt[i];
      end
      ctrl_r <= ctrl_nxt;
      line_cnt_r <= line_cnt_nxt;
      dot_word_r <= dot_word_nxt;
    end
  end

  // Handshake readies are combinational; forced low while enable is low
  assign s_axi_awready_out = ~aw_held_r & clk_en_in & rst_n;
  assign s_axi_wready_out = ~w_held_r & clk_en_in & rst_n;
  assign s_axi_arready_out = ~rvalid_r & clk_en_in & rst_n;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign ctrl_out = ctrl_r;
  assign line_pattern_count_out = line_cnt_r;
  assign dot_step_word_out = dot_word_r;

endmodule : rcd_top

// ### tb/rcd_top_properties.sv
// Checker for the render command decoder: decode fields, line pattern counter.
// Assumes it is bound to rcd_top and sees only that module's ports.
`timescale 1ns/1ps
module rcd_top_chk (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Register bus
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  // Rasterizer side
  input wire logic fragment_step_in,
  input wire rcd_pkg::rcd_ctrl_s ctrl_out,
  input wire logic [15:0] line_pattern_count_out
);
  logic [31:0] cmd_r;
  logic [7:0] adr_r;
  logic [3:0] strb_r;
  logic trap;
  // Only one write in flight, so the last taken address and data belong together
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_r <= 32'h0000_0000;
      adr_r <= 8'hFF;
      strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) adr_r <= s_axi_awaddr_in;
      if (s_axi_wvalid_in && s_axi_wready_out) cmd_r <= s_axi_wdata_in;
      if (s_axi_wvalid_in && s_axi_wready_out) strb_r <= s_axi_wstrb_in;
    end
  end
  assign trap = cmd_r[7:6] == 2'h1;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence cmd_write;
    $rose(s_axi_bvalid_out) && adr_r == rcd_pkg::RCD_OFF_COMMAND && strb_r == 4'hF;
  endsequence
  chk_area_gate: assert property (cmd_write |-> !ctrl_out.area_pattern_gate || cmd_r[0])
    else $error("area gate set with command bit clear");
  chk_line_gate: assert property (cmd_write |-> !ctrl_out.line_pattern_gate || cmd_r[1])
    else $error("line gate set with command bit clear");
  chk_restart_qual: assert property (cmd_write |->
    ctrl_out.line_pattern_restart == (cmd_r[2] && ctrl_out.line_pattern_gate))
    else $error("restart not qualified by line gate");
  chk_restart_clear: assert property (cmd_write ##0 ctrl_out.line_pattern_restart && ctrl_out.start |->
    ##[0:1] line_pattern_count_out == 16'h0000)
    else $error("line counter not cleared");
  chk_counter_step: assert property (fragment_step_in && ctrl_out.line_pattern_gate && clk_en_in |=>
    $rose(s_axi_bvalid_out) || line_pattern_count_out == $past(line_pattern_count_out) + 16'h0001)
    else $error("line counter did not advance");
  chk_fill_trap: assert property (cmd_write |-> ctrl_out.span_fill_select == (cmd_r[3] && trap))
    else $error("span fill wrong");
  chk_fill_size: assert property (cmd_write |-> ctrl_out.block_fill_size == rcd_pkg::RCD_BLOCK_FILL)
    else $error("block fill size wrong");
  chk_prim_start: assert property (cmd_write |->
    ctrl_out.prim == cmd_r[7:6] && ctrl_out.start == (cmd_r[7:6] != 2'h3))
    else $error("primitive or start wrong");
  chk_smooth_trap: assert property (cmd_write |-> ctrl_out.edge_smoothing_on == (cmd_r[8] && trap))
    else $error("smoothing wrong");
  chk_grid_select: assert property (cmd_write |-> ctrl_out.subsample_grid_select == cmd_r[9])
    else $error("grid select wrong");
  chk_table_step: assert property (cmd_write |->
    ctrl_out.dot_table_step_select == (cmd_r[10] && cmd_r[8] && trap))
    else $error("table step select wrong");
endmodule : rcd_top_chk
bind rcd_top rcd_top_chk u_chk (.clk_sys_in, .reset_n_in, .clk_en_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bvalid_out, .fragment_step_in, .ctrl_out, .line_pattern_count_out);

// ### tb/testbench.sv
// Self-checking bench for rcd_top: register bus, command decode, counter, step table.
// Assumes the package, design and checker are compiled first; drives every port itself.
`timescale 1ns/1ps
module testbench;
  logic clk_sys_in, reset_n_in, clk_en_in, aw_v, w_v, b_r, ar_v, r_r, step, busy;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d, dot, rd, c;
  logic [3:0] w_s;
  logic [1:0] b_resp, r_resp, idx, resp;
  logic [15:0] cnt;
  logic [31:0] opts [3] = '{32'h0000_073F, 32'h0000_0400, 32'h0000_0000};
  rcd_pkg::rcd_ctrl_s ctrl, seen;
  int errors, compares;
  rcd_top dut (.clk_sys_in, .reset_n_in, .clk_en_in, .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
    .s_axi_awready_out(aw_rdy), .s_axi_wdata_in(w_d), .s_axi_wstrb_in(w_s), .s_axi_wvalid_in(w_v),
    .s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_v), .s_axi_bready_in(b_r),
    .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v), .s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_d),
    .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_r), .fragment_step_in(step),
    .raster_busy_in(busy), .ctrl_out(ctrl), .line_pattern_count_out(cnt), .dot_step_word_out(dot),
    .dot_step_index_in(idx));
  task automatic chk(input string name, input logic [63:0] seen_v, input logic [63:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // Handshakes are sampled at the falling edge, where every input is settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk_sys_in);
    aw_a <= a;
    w_d <= d;
    w_s <= 4'hF;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (!tb) begin
      @(negedge clk_sys_in);
      ta = aw_v && aw_rdy;
      tw = w_v && w_rdy;
      tb = b_v;
      resp = b_resp;
      seen = ctrl;
      @(posedge clk_sys_in);
      if (ta) aw_v <= 1'b0;
      if (tw) w_v <= 1'b0;
      if (tb) b_r <= 1'b0;
    end
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    logic ta, tb;
    tb = 1'b0;
    @(posedge clk_sys_in);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    while (!tb) begin
      @(negedge clk_sys_in);
      ta = ar_v && ar_rdy;
      tb = r_v;
      rd = r_d;
      resp = r_resp;
      @(posedge clk_sys_in);
      if (ta) ar_v <= 1'b0;
      if (tb) r_r <= 1'b0;
    end
  endtask : rd_reg
  task automatic frag(input int n);
    step <= 1'b1;
    repeat (n) @(posedge clk_sys_in);
    step <= 1'b0;
    @(negedge clk_sys_in);
  endtask : frag
  function automatic logic [63:0] pick(input rcd_pkg::rcd_ctrl_s s);
    return {s.count, s.start, s.prim, s.area_pattern_gate, s.line_pattern_gate, s.line_pattern_restart,
      s.span_fill_select, s.span_op_field, s.edge_smoothing_on, s.subsample_grid_select, s.dot_table_step_select,
      s.block_fill_size, s.count_unit};
  endfunction : pick
  function automatic logic [63:0] expect_ctrl(input logic [31:0] v, input logic [1:0] u);
    logic trap, line, sm, fill;
    logic [1:0] unit;
    trap = v[7:6] == 2'h1;
    line = v[1] & u[1];
    sm = v[8] & trap;
    fill = v[3] & trap;
    unit = v[7:6] == 2'h0 ? rcd_pkg::RCD_UNIT_PIXELS : (trap ? (sm ? rcd_pkg::RCD_UNIT_SUBLINES :
      rcd_pkg::RCD_UNIT_SCANLINES) : rcd_pkg::RCD_UNIT_DIAMETER);
    // Span op 2 comes from the unit control words written by the scenarios
    return {16'h0005, v[7:6] != 2'h3, v[7:6], v[0] & u[0], line, v[2] & line, fill, fill ? 2'h2 : 2'h0, sm, v[9],
      v[10] & sm, rcd_pkg::RCD_BLOCK_FILL, unit};
  endfunction : expect_ctrl
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors++;
    end_sim();
  end
  initial begin
    {reset_n_in, aw_v, w_v, b_r, ar_v, r_r, step, aw_a, ar_a, w_d, w_s, idx} = '0;
    {clk_en_in, busy} = 2'b11;
    errors = 0;
    compares = 0;
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    rd_reg(rcd_pkg::RCD_OFF_STATUS);
    chk("status_busy", rd[0], 1'b1);
    wr(rcd_pkg::RCD_OFF_COUNT, 32'h0001_0005);
    wr(rcd_pkg::RCD_OFF_UNIT_CTRL, 32'h0000_0023);
    chk("wr_resp", resp, rcd_pkg::RCD_RESP_OKAY);
    wr(rcd_pkg::RCD_OFF_COMMAND, 32'h0000_0002);
    frag(3);
    chk("count_a", cnt, 16'h0003);
    wr(rcd_pkg::RCD_OFF_COMMAND, 32'h0000_0002);
    frag(2);
    chk("count_b", cnt, 16'h0005);
    wr(rcd_pkg::RCD_OFF_COMMAND, 32'h0000_0006);
    @(negedge clk_sys_in);
    chk("count_clr", cnt, 16'h0000);
    frag(1);
    wr(rcd_pkg::RCD_OFF_COMMAND, 32'h0000_0004);
    frag(2);
    rd_reg(rcd_pkg::RCD_OFF_LINE_CNT);
    chk("count_gated", rd, 32'h0000_0001);
    // Clock enable low must freeze the counter, then counting carries on
    wr(rcd_pkg::RCD_OFF_COMMAND, 32'h0000_0002);
    @(posedge clk_sys_in);
    clk_en_in <= 1'b0;
    frag(3);
    chk("count_frozen", cnt, 16'h0001);
    @(posedge clk_sys_in);
    clk_en_in <= 1'b1;
    frag(1);
    chk("count_resume", cnt, 16'h0002);
    for (int u = 0; u < 2; u++) begin
      wr(rcd_pkg::RCD_OFF_UNIT_CTRL, u ? 32'h0000_0023 : 32'h0000_0020);
      for (int p = 0; p < 4; p++) begin
        foreach (opts[o]) begin
          c = opts[o] | (32'(p) << 6);
          wr(rcd_pkg::RCD_OFF_COMMAND, c);
          chk("ctrl", pick(seen), expect_ctrl(c, u ? 2'h3 : 2'h0));
        end
      end
    end
    for (int i = 0; i < 4; i++) wr(rcd_pkg::RCD_OFF_TABLE0 + 8'(4 * i), 32'hA5A5_0000 | 32'(i));
    for (int i = 0; i < 4; i++) begin
      rd_reg(rcd_pkg::RCD_OFF_TABLE0 + 8'(4 * i));
      chk("table_rd", rd, 32'hA5A5_0000 | 32'(i));
    end
    wr(rcd_pkg::RCD_OFF_COMMAND, 32'h0000_0540);
    for (int i = 3; i >= 0; i--) begin
      @(posedge clk_sys_in);
      idx <= 2'(i);
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk("dot_word", dot, 32'hA5A5_0000 | 32'(i));
    end
    wr(rcd_pkg::RCD_OFF_COMMAND, 32'h0000_0140);
    repeat (2) @(negedge clk_sys_in);
    chk("dot_off", dot, 32'h0000_0000);
    @(posedge clk_sys_in);
    busy <= 1'b0;
    rd_reg(rcd_pkg::RCD_OFF_STATUS);
    chk("status_word", rd, 32'h0104_0202);
    wr(8'h30, 32'hFFFF_FFFF);
    chk("bad_wr", resp, rcd_pkg::RCD_RESP_SLVERR);
    rd_reg(8'h3C);
    chk("bad_rd", {resp, rd}, {rcd_pkg::RCD_RESP_SLVERR, 32'h0000_0000});
    rd_reg(rcd_pkg::RCD_OFF_COMMAND);
    chk("cmd_rd", rd, 32'h0000_0000);
    end_sim();
  end
endmodule : testbench
